// ==== hdl/cmd_mode_defines.svh ====
// Register offsets, reset values and field constants of the command and mode selector.
`ifndef CMD_MODE_DEFINES_SVH
`define CMD_MODE_DEFINES_SVH
// Printed offsets are register indices; byte address is four times the index.
`define IDX_TORQUE_SCALE      16'h2210
`define IDX_TORQUE_OFFSET     16'h2211
`define IDX_TORQUE_CLAMP      16'h2212
`define IDX_TORQUE_FILTER     16'h2213
`define IDX_SPD_LIMIT_SEL     16'h230d
`define IDX_TQ_SPD_LIMIT      16'h230e
`define IDX_PRESET_BASE       16'h2312
`define IDX_PRESET_LAST       16'h2319
`define IDX_VEL_SRC_SEL       16'h231a
`define IDX_CTRL_MODE         16'h3000
`define IDX_TQ_LIMIT_FUNC     16'h2110
`define IDX_SOFT_INPUTS       16'h3f00
`define IDX_STATUS            16'h3f01
`define RST_TORQUE_SCALE      16'h0064
`define RST_TQ_SPD_LIMIT      16'h03e8
`define RST_ZERO16            16'h0000
`define SCALE_MAX             16'sh03e8
`define SCALE_MIN             -16'sh03e8
`define TQ_LIMIT_ANALOG       16'h0004
`define VSRC_ANALOG           2'h0
`define VSRC_TWO_BITS         2'h1
`define VSRC_THREE_BITS       2'h2
`define VSRC_PRESET_ONLY      2'h3
`define SPD_ALL_TWO           3'h3
`define SPD_ALL_THREE         3'h7
`define IDX_LOW_BITS          14
`define PRESET_COUNT          8
`define SCALE_DIV             32'sh000003e8
`define MAX_MOTOR_SPEED_RPM   16'h1770
`define SPD_LIMIT_MAX_BIT     0
`define CM_INDEX              4'h0
`define CM_PULSE              4'h1
`define CM_VEL                4'h2
`define CM_TORQUE             4'h3
`define CM_PULSE_INDEX        4'h4
`define CM_PULSE_VEL          4'h5
`define CM_PULSE_TORQUE       4'h6
`define CM_VEL_TORQUE         4'h7
`define CM_INDEX_VEL          4'h8
`define CM_INDEX_TORQUE       4'h9
`endif

// ==== hdl/cmd_mode_pkg.sv ====
// Types shared by the command and mode selector.
package cmd_mode_pkg;
  typedef enum logic [1:0] {
    OP_INDEX_POS,
    OP_PULSE_POS,
    OP_VELOCITY,
    OP_TORQUE
  } op_mode_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic        use_analog_vel;
    logic [15:0] velocity_cmd;
    logic [15:0] torque_cmd;
    logic        torque_limit_analog;
    logic [15:0] speed_limit;
  } cmd_out_t;
endpackage : cmd_mode_pkg

// ==== hdl/servo_command_mode_select.sv ====
// Command source, torque scaling, speed limit and operating mode selection.
// Functional notes
// (RULE1) Presets used only when source selector 1-3.
// (RULE2) Speed selects from connector pins or software.
// (RULE3) Index from selects, bit0 lowest, picks preset.
// (RULE4) Selector 1: two selects, both on analog.
// (RULE5) Selector 2: all on analog; 0 analog.
// (RULE6) Selector 3: presets only, analog ignored.
// (RULE7) Signed torque scale, +-1000, reset 100.
// (RULE8) Limit function 4: scaled analog torque limit.
// (RULE9) Torque mode: scale gives command at 10V.
// (RULE10) Speed limit: programmed value or motor maximum.
// (RULE11) Programmed speed limit resets to 1000 rpm.
// (RULE12) Mode from control setting and mode input.
// (RULE13) Settings 0-3 fix mode, input ignored.
// (RULE14) Settings 4-6: pulse position, else index/vel/torque.
// (RULE15) Setting 7: velocity, else torque.
// (RULE16) Settings 8-9: index position, else velocity/torque.
// (RULE17) Dual settings start in basic mode.
// (RULE18) Mode and speed inputs synchronised first.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cmd_mode_defines.svh"
module servo_command_mode_select
  import cmd_mode_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              rst_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [15:0]       wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic                   wb_ack_out,
  output logic                   wb_err_out,
  output logic [31:0]            wb_dat_out,
  input  wire logic [2:0]        io_connector_speed_sel_in,
  input  wire logic              io_connector_mode_sel_in,
  input  wire logic signed [15:0] analog_torque_in,
  output op_mode_t               op_mode_out,
  output cmd_out_t               cmd_out
);
  wb_req_t req;
  assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in, adr: wb_adr_in,
                 sel: wb_sel_in, dat: wb_dat_in};

  // Register state.
  logic [15:0] scale_reg, scale_next;
  // Offset, clamp and filter are stored for software only; nothing in this block reads them.
  logic [15:0] toffs_reg, toffs_next;
  logic [15:0] tclamp_reg, tclamp_next;
  logic [15:0] tfilt_reg, tfilt_next;
  logic [15:0] slsel_reg, slsel_next;
  logic [15:0] tqlim_reg, tqlim_next;
  logic [15:0] tqfunc_reg, tqfunc_next;
  logic [1:0]  vsrc_reg, vsrc_next;
  logic [3:0]  cmode_reg, cmode_next;
  logic [3:0]  soft_reg, soft_next;
  logic [15:0] preset_reg [`PRESET_COUNT];
  logic [15:0] preset_next [`PRESET_COUNT];
  logic        ack_reg, ack_next;
  logic        err_reg, err_next;
  logic [31:0] rdat_reg, rdat_next;

  // Input synchronisers.
  // The pins are asynchronous to the drive clock, so only the second stage is read by logic.
  logic [3:0] sync1_reg, sync2_reg;
  logic [3:0] sync1_next, sync2_next;
  always_comb
  begin
    sync1_next = {io_connector_mode_sel_in, io_connector_speed_sel_in}; // [RULE18]
    sync2_next = sync1_reg;
  end
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  logic [2:0] speed_sel;
  logic       mode_sel;
  // Either route may drive a select; software bits OR with the pins.
  assign speed_sel = sync2_reg[2:0] | soft_reg[2:0]; // [RULE2]
  assign mode_sel  = sync2_reg[3] | soft_reg[3];

  // Bus decode: one-cycle ack, err for unmapped indices.
  logic        hit;
  logic        mapped;
  logic [15:0] idx;
  logic [15:0] rd_val;
  logic [15:0] wval;
  logic signed [15:0] wsig;
  // A request is not taken in the cycle its answer is shown; one still held after that cycle is answered again.
  assign hit  = req.cyc && req.stb && !ack_reg && !err_reg;
  // Misaligned byte addresses carry their low bits to the top and so hit no register.
  assign idx  = {2'h0, req.adr[15:2]} | {req.adr[1:0], 14'h0};
  // Only sel[1:0] matter; a byte lane left off is written as zero, not kept.
  assign wval = {req.sel[1] ? req.dat[15:8] : 8'h00, req.sel[0] ? req.dat[7:0] : 8'h00};
  assign wsig = wval;

  always_comb
  begin
    mapped = 1'b1;
    rd_val = `RST_ZERO16;
    if (idx >= `IDX_PRESET_BASE && idx <= `IDX_PRESET_LAST)
      rd_val = preset_reg[3'(idx - `IDX_PRESET_BASE)];
    else
    begin
      case (idx)
        `IDX_TORQUE_SCALE:  rd_val = scale_reg;
        `IDX_TORQUE_OFFSET: rd_val = toffs_reg;
        `IDX_TORQUE_CLAMP:  rd_val = tclamp_reg;
        `IDX_TORQUE_FILTER: rd_val = tfilt_reg;
        `IDX_SPD_LIMIT_SEL: rd_val = slsel_reg;
        `IDX_TQ_SPD_LIMIT:  rd_val = tqlim_reg;
        `IDX_TQ_LIMIT_FUNC: rd_val = tqfunc_reg;
        `IDX_VEL_SRC_SEL:   rd_val = {14'h0, vsrc_reg};
        `IDX_CTRL_MODE:     rd_val = {12'h0, cmode_reg};
        `IDX_SOFT_INPUTS:   rd_val = {12'h0, soft_reg};
        `IDX_STATUS:        rd_val = {9'h0, cmd_out.use_analog_vel, mode_sel, speed_sel,
                                      op_mode_out};
        default:            mapped = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    scale_next  = scale_reg;
    toffs_next  = toffs_reg;
    tclamp_next = tclamp_reg;
    tfilt_next  = tfilt_reg;
    slsel_next  = slsel_reg;
    tqlim_next  = tqlim_reg;
    tqfunc_next = tqfunc_reg;
    vsrc_next   = vsrc_reg;
    cmode_next  = cmode_reg;
    soft_next   = soft_reg;
    for (int i = 0; i < `PRESET_COUNT; i++)
      preset_next[i] = preset_reg[i];
    ack_next  = hit && mapped;
    err_next  = hit && !mapped;
    // Read data is zero outside an answer, so a stray sample never shows stale data.
    rdat_next = (hit && mapped && !req.we) ? {16'h0, rd_val} : 32'h0;
    if (hit && mapped && req.we)
    begin
      if (idx >= `IDX_PRESET_BASE && idx <= `IDX_PRESET_LAST)
        preset_next[3'(idx - `IDX_PRESET_BASE)] = wval;
      else
      begin
        case (idx)
          `IDX_TORQUE_SCALE:
            // Out-of-range factors are clamped to keep the product bounded.
            if (wsig > `SCALE_MAX)
              scale_next = `SCALE_MAX; // [RULE7]
            else if (wsig < `SCALE_MIN)
              scale_next = `SCALE_MIN; // [RULE7]
            else
              scale_next = wval; // [RULE7]
          `IDX_TORQUE_OFFSET: toffs_next  = wval;
          `IDX_TORQUE_CLAMP:  tclamp_next = wval;
          `IDX_TORQUE_FILTER: tfilt_next  = wval;
          `IDX_SPD_LIMIT_SEL: slsel_next  = wval;
          `IDX_TQ_SPD_LIMIT:  tqlim_next  = wval;
          `IDX_TQ_LIMIT_FUNC: tqfunc_next = wval;
          `IDX_VEL_SRC_SEL:   vsrc_next   = wval[1:0];
          `IDX_CTRL_MODE:     cmode_next  = wval[3:0];
          `IDX_SOFT_INPUTS:   soft_next   = wval[3:0]; // [RULE2]
          // The status word is read-only; a write to it is answered and dropped.
          default:            soft_next   = soft_reg;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      scale_reg  <= `RST_TORQUE_SCALE; // [RULE7]
      toffs_reg  <= `RST_ZERO16;
      tclamp_reg <= `RST_ZERO16;
      tfilt_reg  <= `RST_ZERO16;
      slsel_reg  <= `RST_ZERO16;
      tqlim_reg  <= `RST_TQ_SPD_LIMIT; // [RULE11]
      tqfunc_reg <= `RST_ZERO16;
      vsrc_reg   <= `VSRC_ANALOG;
      cmode_reg  <= `CM_INDEX;
      soft_reg   <= 4'h0;
      for (int i = 0; i < `PRESET_COUNT; i++)
        preset_reg[i] <= `RST_ZERO16;
      ack_reg  <= 1'b0;
      err_reg  <= 1'b0;
      rdat_reg <= 32'h0;
    end
    else
    begin
      scale_reg  <= scale_next;
      toffs_reg  <= toffs_next;
      tclamp_reg <= tclamp_next;
      tfilt_reg  <= tfilt_next;
      slsel_reg  <= slsel_next;
      tqlim_reg  <= tqlim_next;
      tqfunc_reg <= tqfunc_next;
      vsrc_reg   <= vsrc_next;
      cmode_reg  <= cmode_next;
      soft_reg   <= soft_next;
      for (int i = 0; i < `PRESET_COUNT; i++)
        preset_reg[i] <= preset_next[i];
      ack_reg  <= ack_next;
      err_reg  <= err_next;
      rdat_reg <= rdat_next;
    end
  end
  assign wb_ack_out = ack_reg;
  assign wb_err_out = err_reg;
  assign wb_dat_out = rdat_reg;

  // Operating mode; a dual setting falls to its basic mode while the input is off,
  // which also covers power-up since the synchroniser resets to off.
  op_mode_t mode_reg, mode_next;
  always_comb
  begin
    case (cmode_reg) // [RULE12]
      `CM_INDEX:        mode_next = OP_INDEX_POS; // [RULE13]
      `CM_PULSE:        mode_next = OP_PULSE_POS; // [RULE13]
      `CM_VEL:          mode_next = OP_VELOCITY; // [RULE13]
      `CM_TORQUE:       mode_next = OP_TORQUE; // [RULE13]
      `CM_PULSE_INDEX:  mode_next = mode_sel ? OP_INDEX_POS : OP_PULSE_POS; // [RULE14] [RULE17]
      `CM_PULSE_VEL:    mode_next = mode_sel ? OP_VELOCITY : OP_PULSE_POS; // [RULE14]
      `CM_PULSE_TORQUE: mode_next = mode_sel ? OP_TORQUE : OP_PULSE_POS; // [RULE14]
      `CM_VEL_TORQUE:   mode_next = mode_sel ? OP_TORQUE : OP_VELOCITY; // [RULE15] [RULE17]
      `CM_INDEX_VEL:    mode_next = mode_sel ? OP_VELOCITY : OP_INDEX_POS; // [RULE16]
      `CM_INDEX_TORQUE: mode_next = mode_sel ? OP_TORQUE : OP_INDEX_POS; // [RULE16]
      // Codes 10 to 15 are undefined; the last mode is held rather than guessed.
      default:          mode_next = mode_reg;
    endcase
  end

  // Registered once after the two-stage synchroniser, so a pin change reaches the mode on the third edge.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
      mode_reg <= OP_INDEX_POS;
    else
      mode_reg <= mode_next;
  end

  // Command outputs.
  cmd_out_t    cmd_reg, cmd_next;
  logic        analog_vel;
  logic signed [31:0] tq_prod;
  always_comb
  begin
    // Selector 1 ignores the third select; its all-on pair means analog.
    case (vsrc_reg)
      `VSRC_ANALOG:      analog_vel = 1'b1; // [RULE5]
      `VSRC_TWO_BITS:    analog_vel = ({1'b0, speed_sel[1:0]} == `SPD_ALL_TWO); // [RULE4]
      `VSRC_THREE_BITS:  analog_vel = (speed_sel == `SPD_ALL_THREE); // [RULE5]
      `VSRC_PRESET_ONLY: analog_vel = 1'b0; // [RULE6]
      default:           analog_vel = 1'b1;
    endcase
    // Full scale input of 10 V maps to the scale value in tenths of a percent.
    // A 16 by 16 bit product fits 32 bits; the division truncates toward zero.
    tq_prod = 32'(analog_torque_in) * 32'($signed(scale_reg)); // [RULE9]
    cmd_next.use_analog_vel = analog_vel; // [RULE1]
    if (vsrc_reg == `VSRC_TWO_BITS)
      cmd_next.velocity_cmd = preset_reg[{1'b0, speed_sel[1:0]}]; // [RULE4]
    else
      cmd_next.velocity_cmd = preset_reg[speed_sel]; // [RULE3]
    // Zero while analog is selected, so no stale preset reaches the velocity loop.
    if (analog_vel)
      cmd_next.velocity_cmd = `RST_ZERO16; // [RULE1]
    cmd_next.torque_cmd = 16'(tq_prod / `SCALE_DIV); // [RULE9]
    cmd_next.torque_limit_analog = (mode_reg != OP_TORQUE) &&
                                   (tqfunc_reg == `TQ_LIMIT_ANALOG); // [RULE8]
    // Driven in every mode so the loop sees no step when torque operation starts.
    cmd_next.speed_limit = slsel_reg[`SPD_LIMIT_MAX_BIT] ? `MAX_MOTOR_SPEED_RPM : tqlim_reg; // [RULE10]
  end

  always_ff @(posedge mclk_in)
  begin
    // Outputs are registered so every consumer sees one settled value per clock.
    if (rst_in)
    begin
      cmd_reg  <= '0;
    end
    else
    begin
      cmd_reg  <= cmd_next;
    end
  end
  assign op_mode_out = mode_reg;
  assign cmd_out     = cmd_reg;
endmodule : servo_command_mode_select

// ==== tb/servo_cmd_monitor.sv ====
// Port checker for the command and mode selector.
`timescale 1ns/1ps
module servo_cmd_monitor
  import cmd_mode_pkg::*;
(
  input wire logic               mclk_in,
  input wire logic               rst_in,
  input wire logic               wb_cyc_in,
  input wire logic               wb_stb_in,
  input wire logic               wb_we_in,
  input wire logic [15:0]        wb_adr_in,
  input wire logic [3:0]         wb_sel_in,
  input wire logic [31:0]        wb_dat_in,
  input wire logic               wb_ack_out,
  input wire logic               wb_err_out,
  input wire logic [31:0]        wb_dat_out,
  input wire logic [2:0]         io_connector_speed_sel_in,
  input wire logic               io_connector_mode_sel_in,
  input wire logic signed [15:0] analog_torque_in,
  input wire op_mode_t           op_mode_out,
  input wire cmd_out_t           cmd_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
  endsequence
  sequence s_answer;
    (wb_ack_out ^ wb_err_out) ##1 !(wb_ack_out || wb_err_out);
  endsequence
  sequence s_quiet;
    !wb_ack_out && $stable(io_connector_mode_sel_in) && $stable(io_connector_speed_sel_in);
  endsequence
  a_bus_answer_once: assert property (s_req |=> s_answer)
    else $error("bus answer missing or too long");
  a_idle_no_answer: assert property (
    !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out && !wb_err_out)
    else $error("answer without request");
  a_read_data_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  a_read_upper_zero: assert property (wb_ack_out |-> wb_dat_out[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_analog_no_preset: assert property (
    cmd_out.use_analog_vel |-> cmd_out.velocity_cmd == 16'h0)
    else $error("preset shown while analog selected");
  a_mode_input_sync: assert property (s_quiet [*8] |=> $stable(op_mode_out))
    else $error("mode changed without cause");
  a_reset_start_mode: assert property (
    $fell(rst_in) |-> op_mode_out == OP_INDEX_POS && cmd_out == '0)
    else $error("outputs not cleared by reset");
  a_torque_zero_in: assert property (
    (analog_torque_in == 16'sh0) [*3] |=> cmd_out.torque_cmd == 16'h0)
    else $error("torque command without input");
  a_torque_mode_limit: assert property (
    $past(op_mode_out) == OP_TORQUE |-> !cmd_out.torque_limit_analog)
    else $error("analog torque limit active in torque operation");
endmodule : servo_cmd_monitor
bind servo_command_mode_select servo_cmd_monitor servo_cmd_monitor_inst (
  .mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_ack_out(wb_ack_out), .wb_err_out(wb_err_out), .wb_dat_out(wb_dat_out),
  .io_connector_speed_sel_in(io_connector_speed_sel_in),
  .io_connector_mode_sel_in(io_connector_mode_sel_in), .analog_torque_in(analog_torque_in),
  .op_mode_out(op_mode_out), .cmd_out(cmd_out));

// ==== tb/host_io_model.sv ====
// Host controller model driving the speed, mode and analog torque inputs.
`timescale 1ns/1ps
module host_io_model (
  input  wire logic          mclk_in,
  output logic [2:0]         speed_sel_out,
  output logic               mode_sel_out,
  output logic signed [15:0] analog_out
);
  initial
  begin
    speed_sel_out = 3'h0;
    mode_sel_out = 1'b0;
    analog_out = 16'sh0;
  end
  // Levels change just after an edge, like a controller's output stage.
  task automatic apply(input logic [2:0] spd, input logic mode, input logic signed [15:0] ana);
    @(posedge mclk_in);
    speed_sel_out <= spd;
    mode_sel_out <= mode;
    analog_out <= ana;
  endtask : apply
endmodule : host_io_model

// ==== tb/testbench.sv ====
// Self-checking bench for the command and mode selector.
`timescale 1ns/1ps
`include "cmd_mode_defines.svh"
module testbench;
  import cmd_mode_pkg::*;
  logic              mclk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [15:0]       adr = 16'h0;
  logic [31:0]       wdat = 32'h0;
  logic              ack;
  logic              err;
  logic [31:0]       rdat;
  logic [31:0]       rd;
  logic [31:0]       seen;
  op_mode_t          exp_m;
  logic              err_seen;
  logic [2:0]        spd;
  logic              mode;
  logic signed [15:0] ana;
  op_mode_t          op_mode;
  cmd_out_t          cmd;
  int                n_mismatch = 0;
  int                compares = 0;
  int                cycles = 0;
  op_mode_t basic[10] = '{OP_INDEX_POS, OP_PULSE_POS, OP_VELOCITY, OP_TORQUE, OP_PULSE_POS,
                          OP_PULSE_POS, OP_PULSE_POS, OP_VELOCITY, OP_INDEX_POS, OP_INDEX_POS};
  op_mode_t switched[10] = '{OP_INDEX_POS, OP_PULSE_POS, OP_VELOCITY, OP_TORQUE, OP_INDEX_POS,
                             OP_VELOCITY, OP_TORQUE, OP_TORQUE, OP_VELOCITY, OP_TORQUE};
  always #20 mclk_in = ~mclk_in;
  host_io_model host_io_model_inst (.mclk_in(mclk_in), .speed_sel_out(spd),
    .mode_sel_out(mode), .analog_out(ana));
  servo_command_mode_select servo_command_mode_select_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h3),
    .wb_dat_in(wdat), .wb_ack_out(ack), .wb_err_out(err), .wb_dat_out(rdat),
    .io_connector_speed_sel_in(spd), .io_connector_mode_sel_in(mode),
    .analog_torque_in(ana), .op_mode_out(op_mode), .cmd_out(cmd));
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Holds the request until the answer edge; data and error are taken at that edge.
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx[13:0], 2'b00};
    wdat <= d;
    do @(posedge mclk_in); while (ack !== 1'b1 && err !== 1'b1);
    rd = rdat;
    err_seen = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic settle;
    repeat (10) @(posedge mclk_in);
  endtask : settle
  function automatic logic [31:0] exp_vel(input int vs, input logic [2:0] s);
    logic [2:0] k;
    k = (vs == 1) ? {1'b0, s[1:0]} : s;
    if (vs == 0 || (vs == 1 && k == 3'h3) || (vs == 2 && k == 3'h7))
      return 32'h10000;
    return 32'h0100 + 32'(k);
  endfunction : exp_vel
  initial
  begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    bus(1'b0, `IDX_TORQUE_SCALE, 32'h0);
    chk("scale reset", 32'h0064, rd);
    bus(1'b0, `IDX_TQ_SPD_LIMIT, 32'h0);
    chk("speed limit reset", 32'h03e8, rd);
    bus(1'b0, 16'h0123, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err_seen});
    bus(1'b1, `IDX_TORQUE_SCALE, 32'h0500);
    bus(1'b0, `IDX_TORQUE_SCALE, 32'h0);
    chk("scale clamp high", 32'h03e8, rd);
    bus(1'b1, `IDX_TORQUE_SCALE, 32'hfc00);
    bus(1'b0, `IDX_TORQUE_SCALE, 32'h0);
    chk("scale clamp low", 32'hfc18, rd);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
      bus(1'b1, `IDX_PRESET_BASE + 16'(i), 32'h0100 + 32'(i));
    for (int vs = 0; vs < 4; vs++)
      for (int s = 0; s < 8; s++)
      begin
        bus(1'b1, `IDX_VEL_SRC_SEL, 32'(vs));
        host_io_model_inst.apply(3'(s), 1'b0, 16'sh0);
        settle();
        seen = 32'({cmd.use_analog_vel, cmd.velocity_cmd});
        chk("velocity source", exp_vel(vs, 3'(s)), seen);
      end
    host_io_model_inst.apply(3'h0, 1'b0, 16'sh0);
    bus(1'b1, `IDX_SOFT_INPUTS, 32'h5);
    settle();
    chk("software speed select", 32'h0105, {cmd.use_analog_vel, cmd.velocity_cmd});
    bus(1'b1, `IDX_SOFT_INPUTS, 32'h0);
    $display("test velocity source done");
    for (int cm = 0; cm < 10; cm++)
      for (int m = 0; m < 2; m++)
      begin
        bus(1'b1, `IDX_CTRL_MODE, 32'(cm));
        host_io_model_inst.apply(3'h0, m[0], 16'sh0);
        settle();
        exp_m = m ? switched[cm] : basic[cm];
        chk("mode", exp_m, op_mode);
      end
    $display("test modes done");
    host_io_model_inst.apply(3'h0, 1'b0, 16'sh1000);
    bus(1'b1, `IDX_CTRL_MODE, 32'h3);
    bus(1'b1, `IDX_TORQUE_SCALE, 32'h03e8);
    settle();
    chk("torque full scale", 32'h1000, 32'(cmd.torque_cmd));
    bus(1'b1, `IDX_TORQUE_SCALE, 32'hfe0c);
    settle();
    chk("torque negative scale", 32'hf800, 32'(cmd.torque_cmd));
    // The analog limit applies only outside torque operation, so velocity mode is chosen first.
    bus(1'b1, `IDX_CTRL_MODE, 32'h2);
    for (int f = 3; f < 6; f++)
    begin
      bus(1'b1, `IDX_TQ_LIMIT_FUNC, 32'(f));
      settle();
      chk("analog torque limit", 32'(f == 4), 32'(cmd.torque_limit_analog));
    end
    bus(1'b1, `IDX_TQ_LIMIT_FUNC, 32'h4);
    bus(1'b1, `IDX_CTRL_MODE, 32'h3);
    settle();
    chk("torque mode limit", 32'h0, 32'(cmd.torque_limit_analog));
    bus(1'b1, `IDX_SPD_LIMIT_SEL, 32'h0);
    settle();
    chk("programmed speed limit", 32'h03e8, 32'(cmd.speed_limit));
    bus(1'b1, `IDX_SPD_LIMIT_SEL, 32'h1);
    settle();
    chk("maximum speed limit", 32'h1770, 32'(cmd.speed_limit));
    bus(1'b1, `IDX_SPD_LIMIT_SEL, 32'h0);
    bus(1'b1, `IDX_TQ_SPD_LIMIT, 32'h07d0);
    settle();
    chk("new speed limit", 32'h07d0, 32'(cmd.speed_limit));
    $display("test torque done");
    rst_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    bus(1'b0, `IDX_TORQUE_SCALE, 32'h0);
    chk("scale after reset", 32'h0064, rd);
    bus(1'b0, `IDX_TQ_SPD_LIMIT, 32'h0);
    chk("speed limit after reset", 32'h03e8, rd);
    $display("test reset done");
    print_verdict();
  end
endmodule : testbench
